// file: design/pdc_pkg.sv
// Shared constants for the palette DAC control link, device end and controller end
package pdc_pkg;
  // Register-select codes on the device's write port
  localparam logic [3:0] RS_PAGE = 4'h1;
  localparam logic [3:0] RS_READ_MASK = 4'h2;
  localparam logic [3:0] RS_IN_CLK_SEL = 4'h3;
  localparam logic [3:0] RS_OUT_CLK_SEL = 4'h4;
  localparam logic [3:0] RS_MUX_CTRL = 4'h5;
  localparam logic [3:0] RS_VIDEO_CTRL = 4'h6;
  localparam logic [3:0] RS_HW_RESET = 4'hf;
  //////////////////////////////////////////////////////////////////////////////
  // Reset values of the device registers
  localparam logic [7:0] MUX_CTRL_RST = 8'h2d;
  localparam logic [7:0] IN_CLK_SEL_RST = 8'h00;
  localparam logic [7:0] OUT_CLK_SEL_RST = 8'h3f;
  localparam logic [7:0] VIDEO_CTRL_RST = 8'h03;
  localparam logic [7:0] READ_MASK_RST = 8'hff;
  localparam logic [7:0] PAGE_RST = 8'h00;
  // Mode fields
  localparam logic [5:0] PASS_MODE_CODE = 6'h2d;
  localparam logic [2:0] TRUE_COLOUR_CODE = 3'h1;
  localparam logic [2:0] OCS_RATIO2_CODE = 3'h1;
  localparam int PEDESTAL_BIT = 4;
  localparam int SYNC_ON_GREEN_BIT = 5;
  // Sync and blank pipeline depth in pclk cycles
  localparam int PIPE_NORMAL = 9;
  localparam int PIPE_PASS = 7;
  //////////////////////////////////////////////////////////////////////////////
  // Controller timing, in pclk cycles, pin-clock periods or lines
  localparam logic [1:0] PIN_CLK_HALF = 2'h3;
  localparam logic [3:0] WR_PHASE_CYC = 4'h6;
  localparam logic [7:0] LINE_TOTAL = 8'h28;
  localparam logic [7:0] HBLANK_START = 8'h20;
  localparam logic [7:0] HSYNC_START = 8'h22;
  localparam logic [7:0] HSYNC_END = 8'h25;
  localparam logic [7:0] FRAME_LINES = 8'h14;
  localparam logic [7:0] VBLANK_START = 8'h10;
  localparam logic [7:0] VSYNC_START = 8'h11;
  localparam logic [7:0] VSYNC_END = 8'h12;
  // Controller APB register offsets
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_MPU_CMD = 8'h04;
  localparam logic [7:0] APB_RESET_BURST = 8'h08;
  localparam logic [7:0] APB_PIXEL = 8'h0c;
  localparam logic [7:0] APB_STATUS = 8'h10;
  localparam int CTRL_VIDEO_EN_BIT = 0;
  localparam int CTRL_PASS_SEL_BIT = 1;
endpackage : pdc_pkg

// file: design/pdc_link_if.sv
// Pin-level link between the graphics controller and the palette DAC control
`timescale 1ns/10ps
interface pdc_link_if;
  logic load_clock;
  logic video_control_clock;
  logic passthrough_clock;
  logic [31:0] pixel;
  logic hsync_n;
  logic vsync_n;
  logic blank_n;
  logic passthrough_blank_n;
  logic [3:0] register_select;
  logic wr_n;
  logic [7:0] mpu_data;
  modport device (
    input load_clock, video_control_clock, passthrough_clock, pixel,
    input hsync_n, vsync_n, blank_n, passthrough_blank_n,
    input register_select, wr_n, mpu_data
  );
  modport host (
    output load_clock, video_control_clock, passthrough_clock, pixel,
    output hsync_n, vsync_n, blank_n, passthrough_blank_n,
    output register_select, wr_n, mpu_data
  );
endinterface : pdc_link_if

// file: design/pdc_sync2.sv
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/10ps
module pdc_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : pdc_sync2

// file: design/pdc_device.sv
// Palette DAC control: register port, resets, pixel and sync capture, pipeline
`timescale 1ns/10ps
module pdc_device (
  // Link from the controller
  pdc_link_if.device link,
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pixel path to the palette
  output logic [7:0] palette_addr_q,
  output logic [7:0] overlay_q,
  // Aligned controls to the DACs
  output logic hsync_out_n_q,
  output logic vsync_out_n_q,
  output logic blank_out_n_q,
  output logic green_sync_off_q,
  output logic sync_on_green_q,
  output logic pedestal_on_q,
  // Register and counter state
  output logic pass_mode_q,
  output logic [7:0] mux_ctrl_q,
  output logic [7:0] in_clk_sel_q,
  output logic [7:0] out_clk_sel_q,
  output logic [7:0] video_output_control_q,
  output logic [7:0] read_mask_q,
  output logic [7:0] load_count_q,
  output logic [7:0] control_count_q
);
  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; pin clocks must be slower than a quarter of pclk
  logic [51:0] pin_raw;
  logic [51:0] pin_s;
  logic load_clock_s;
  logic video_control_clock_s;
  logic ptclk_s;
  logic wr_s;
  logic hs_n_s;
  logic vs_n_s;
  logic blank_n_s;
  logic ptblank_n_s;
  logic [3:0] rs_s;
  logic [7:0] data_s;
  logic [31:0] pix_s;

  // Strobe enters inverted so its idle level matches the synchroniser reset value
  assign pin_raw = {link.load_clock, link.video_control_clock, link.passthrough_clock,
                    ~link.wr_n, link.hsync_n, link.vsync_n, link.blank_n,
                    link.passthrough_blank_n, link.register_select, link.mpu_data,
                    link.pixel};

  pdc_sync2 #(
    .WIDTH(52)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(pin_raw),
    .q(pin_s)
  );

  assign {load_clock_s, video_control_clock_s, ptclk_s, wr_s, hs_n_s, vs_n_s, blank_n_s, ptblank_n_s,
          rs_s, data_s, pix_s} = pin_s;

  //////////////////////////////////////////////////////////////////////////////
  // Edge detection on the synchronised pin clocks and strobe
  logic [3:0] prev_q;
  logic load_clock_rise;
  logic video_control_clock_fall;
  logic ptclk_rise;
  logic wr_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 4'h0;
    end else begin
      prev_q <= {load_clock_s, video_control_clock_s, ptclk_s, wr_s};
    end
  end

  assign load_clock_rise = load_clock_s & ~prev_q[3];
  assign video_control_clock_fall = ~video_control_clock_s & prev_q[2];
  assign ptclk_rise = ptclk_s & ~prev_q[1];
  assign wr_rise = ~wr_s & prev_q[0];

  //////////////////////////////////////////////////////////////////////////////
  // Reset sources and register writes
  logic hw_reset;
  logic sw_reset;
  logic reset_evt;
  logic [7:0] page_q;

  assign hw_reset = wr_rise & (rs_s == pdc_pkg::RS_HW_RESET);
  assign sw_reset = wr_rise & (rs_s == pdc_pkg::RS_MUX_CTRL)
                    & (data_s[5:0] == pdc_pkg::PASS_MODE_CODE);
  assign reset_evt = hw_reset | sw_reset;

  // Power-on and both reset events load the pass-through defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_ctrl_q <= pdc_pkg::MUX_CTRL_RST;
      in_clk_sel_q <= pdc_pkg::IN_CLK_SEL_RST;
      out_clk_sel_q <= pdc_pkg::OUT_CLK_SEL_RST;
      video_output_control_q <= pdc_pkg::VIDEO_CTRL_RST;
      read_mask_q <= pdc_pkg::READ_MASK_RST;
      page_q <= pdc_pkg::PAGE_RST;
    end else if (reset_evt) begin
      mux_ctrl_q <= pdc_pkg::MUX_CTRL_RST;
      in_clk_sel_q <= pdc_pkg::IN_CLK_SEL_RST;
      out_clk_sel_q <= pdc_pkg::OUT_CLK_SEL_RST;
      video_output_control_q <= pdc_pkg::VIDEO_CTRL_RST;
      read_mask_q <= pdc_pkg::READ_MASK_RST;
      page_q <= pdc_pkg::PAGE_RST;
    end else if (wr_rise) begin
      case (rs_s)
        pdc_pkg::RS_PAGE: page_q <= data_s;
        pdc_pkg::RS_READ_MASK: read_mask_q <= data_s;
        pdc_pkg::RS_IN_CLK_SEL: in_clk_sel_q <= data_s;
        pdc_pkg::RS_OUT_CLK_SEL: out_clk_sel_q <= data_s;
        pdc_pkg::RS_MUX_CTRL: mux_ctrl_q <= data_s;
        pdc_pkg::RS_VIDEO_CTRL: video_output_control_q <= data_s;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode decode
  logic pass_mode;
  logic true_colour;
  logic two_groups;

  assign pass_mode = (mux_ctrl_q[5:0] == pdc_pkg::PASS_MODE_CODE);
  assign true_colour = (mux_ctrl_q[5:3] == pdc_pkg::TRUE_COLOUR_CODE);
  assign two_groups = ~pass_mode & (out_clk_sel_q[2:0] == pdc_pkg::OCS_RATIO2_CODE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pass_mode_q <= 1'b1;
    end else begin
      pass_mode_q <= pass_mode;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pixel capture and group shifting
  logic pix_latch;
  logic [31:0] word_q;
  logic grp_q;
  logic [15:0] group;

  assign pix_latch = pass_mode ? ptclk_rise : load_clock_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_q <= 32'h0;
      grp_q <= 1'b0;
    end else if (pix_latch) begin
      word_q <= pix_s;
      grp_q <= 1'b0;
    end else if (!grp_q && two_groups) begin
      grp_q <= 1'b1;
    end
  end

  always_comb begin
    if (true_colour) begin
      group = grp_q ? word_q[31:16] : word_q[15:0];
    end else begin
      group = {8'h00, grp_q ? word_q[15:8] : word_q[7:0]};
    end
  end

  // Page bits are merged first, so a zero mask always lands on entry 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      palette_addr_q <= 8'h00;
      overlay_q <= 8'h00;
    end else begin
      palette_addr_q <= (group[7:0] | page_q) & read_mask_q;
      overlay_q <= true_colour ? (word_q[31:24] & read_mask_q) : 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Divider counters, cleared by every reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_count_q <= 8'h00;
      control_count_q <= 8'h00;
    end else if (reset_evt) begin
      load_count_q <= 8'h00;
      control_count_q <= 8'h00;
    end else begin
      if (load_clock_rise) begin
        load_count_q <= load_count_q + 8'h01;
      end
      if (video_control_clock_fall) begin
        control_count_q <= control_count_q + 8'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control sampling and alignment pipeline
  logic [2:0] ctl_q;
  logic [2:0] pipe_q [pdc_pkg::PIPE_NORMAL];
  logic [2:0] tap;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 3'h7;
    end else if (!pass_mode && video_control_clock_fall) begin
      ctl_q <= {hs_n_s, vs_n_s, blank_n_s};
    end else if (pass_mode && ptclk_rise) begin
      ctl_q <= {hs_n_s, vs_n_s, ptblank_n_s};
    end
  end

  // Nine stages, tapped at seven in pass mode, keep controls level with the pixel path, no glue needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < pdc_pkg::PIPE_NORMAL; i++) begin
        pipe_q[i] <= 3'h7;
      end
    end else begin
      pipe_q[0] <= ctl_q;
      for (int i = 1; i < pdc_pkg::PIPE_NORMAL; i++) begin
        pipe_q[i] <= pipe_q[i-1];
      end
    end
  end

  assign tap = pass_mode ? pipe_q[pdc_pkg::PIPE_PASS-1] : pipe_q[pdc_pkg::PIPE_NORMAL-1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hsync_out_n_q <= 1'b1;
      vsync_out_n_q <= 1'b1;
      blank_out_n_q <= 1'b1;
      green_sync_off_q <= 1'b0;
      sync_on_green_q <= 1'b0;
      pedestal_on_q <= 1'b0;
    end else begin
      hsync_out_n_q <= tap[2];
      vsync_out_n_q <= tap[1];
      blank_out_n_q <= tap[0];
      // Blank level is deliberately not looked at here
      green_sync_off_q <= ~tap[2] | ~tap[1];
      sync_on_green_q <= video_output_control_q[pdc_pkg::SYNC_ON_GREEN_BIT];
      pedestal_on_q <= video_output_control_q[pdc_pkg::PEDESTAL_BIT];
    end
  end
endmodule : pdc_device

// file: design/pdc_host.sv
// Graphics controller end: APB registers, pin clocks, video timing, write port
`timescale 1ns/10ps
module pdc_host (
  // Link to the device
  pdc_link_if.host link,
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef enum logic [1:0] {WR_IDLE, WR_LOW, WR_HIGH} pdc_wr_state_t;

  pdc_wr_state_t wr_state_q;
  logic [3:0] wr_cnt_q;
  logic [7:0] burst_q;
  logic [1:0] ctrl_q;
  logic [31:0] pixel_reg_q;
  logic [7:0] hcnt_q;
  logic [7:0] vcnt_q;
  logic [1:0] div_q;
  logic clk_q;
  logic acc;
  logic wr_start;
  logic mapped;

  //////////////////////////////////////////////////////////////////////////////
  // APB slave: no wait states, writes take effect at the ready edge
  assign acc = psel & penable & pready;
  assign mapped = (paddr == pdc_pkg::APB_CTRL) | (paddr == pdc_pkg::APB_MPU_CMD)
                  | (paddr == pdc_pkg::APB_RESET_BURST) | (paddr == pdc_pkg::APB_PIXEL)
                  | (paddr == pdc_pkg::APB_STATUS);
  assign wr_start = acc & pwrite & (wr_state_q == WR_IDLE)
                    & ((paddr == pdc_pkg::APB_MPU_CMD) | (paddr == pdc_pkg::APB_RESET_BURST));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= 32'h0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          pdc_pkg::APB_CTRL: prdata <= {30'h0, ctrl_q};
          pdc_pkg::APB_PIXEL: prdata <= pixel_reg_q;
          pdc_pkg::APB_STATUS: prdata <= {8'h0, vcnt_q, hcnt_q, 7'h0, wr_state_q != WR_IDLE};
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 2'h0;
      pixel_reg_q <= 32'h0;
    end else if (acc && pwrite) begin
      if (paddr == pdc_pkg::APB_CTRL) begin
        ctrl_q <= pwdata[1:0];
      end
      if (paddr == pdc_pkg::APB_PIXEL) begin
        pixel_reg_q <= pwdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register write port; a reset burst repeats the all-high strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_state_q <= WR_IDLE;
      wr_cnt_q <= 4'h0;
      burst_q <= 8'h0;
      link.wr_n <= 1'b1;
      link.register_select <= 4'h0;
      link.mpu_data <= 8'h0;
    end else begin
      unique case (wr_state_q)
        WR_IDLE: begin
          if (wr_start) begin
            if (paddr == pdc_pkg::APB_RESET_BURST) begin
              link.register_select <= pdc_pkg::RS_HW_RESET;
              burst_q <= pwdata[7:0];
            end else begin
              link.register_select <= pwdata[11:8];
              link.mpu_data <= pwdata[7:0];
              burst_q <= 8'h1;
            end
            link.wr_n <= 1'b0;
            wr_cnt_q <= 4'h0;
            wr_state_q <= WR_LOW;
          end
        end
        WR_LOW: begin
          wr_cnt_q <= wr_cnt_q + 4'h1;
          if (wr_cnt_q == pdc_pkg::WR_PHASE_CYC - 4'h1) begin
            link.wr_n <= 1'b1;
            wr_cnt_q <= 4'h0;
            wr_state_q <= WR_HIGH;
          end
        end
        WR_HIGH: begin
          wr_cnt_q <= wr_cnt_q + 4'h1;
          if (wr_cnt_q == pdc_pkg::WR_PHASE_CYC - 4'h1) begin
            wr_cnt_q <= 4'h0;
            if (burst_q > 8'h1) begin
              burst_q <= burst_q - 8'h1;
              link.wr_n <= 1'b0;
              wr_state_q <= WR_LOW;
            end else begin
              burst_q <= 8'h0;
              wr_state_q <= WR_IDLE;
            end
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin clocks, period eight pclk; timing advances on each falling edge
  logic fall;

  assign fall = (div_q == pdc_pkg::PIN_CLK_HALF) & clk_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 2'h0;
      clk_q <= 1'b0;
      link.load_clock <= 1'b0;
      link.video_control_clock <= 1'b0;
      link.passthrough_clock <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      if (div_q == pdc_pkg::PIN_CLK_HALF) begin
        clk_q <= ~clk_q;
        link.load_clock <= ~clk_q;
        link.video_control_clock <= ~clk_q;
        link.passthrough_clock <= ~clk_q;
      end
    end
  end

  localparam logic [7:0] LINE_LAST = pdc_pkg::LINE_TOTAL - 8'h1;
  localparam logic [7:0] FRAME_LAST = pdc_pkg::FRAME_LINES - 8'h1;
  logic in_blank;

  assign in_blank = (hcnt_q >= pdc_pkg::HBLANK_START)
                    | (vcnt_q >= pdc_pkg::VBLANK_START);

  // Sync lies inside blank; only one blank pin is driven per mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt_q <= 8'h0;
      vcnt_q <= 8'h0;
      link.pixel <= 32'h0;
      link.hsync_n <= 1'b1;
      link.vsync_n <= 1'b1;
      link.blank_n <= 1'b1;
      link.passthrough_blank_n <= 1'b1;
    end else if (fall) begin
      link.pixel <= pixel_reg_q;
      if (!ctrl_q[pdc_pkg::CTRL_VIDEO_EN_BIT]) begin
        hcnt_q <= 8'h0;
        vcnt_q <= 8'h0;
        link.hsync_n <= 1'b1;
        link.vsync_n <= 1'b1;
        link.blank_n <= 1'b1;
        link.passthrough_blank_n <= 1'b1;
      end else begin
        hcnt_q <= (hcnt_q == LINE_LAST) ? 8'h0 : hcnt_q + 8'h1;
        if (hcnt_q == LINE_LAST) begin
          vcnt_q <= (vcnt_q == FRAME_LAST) ? 8'h0 : vcnt_q + 8'h1;
        end
        link.hsync_n <= ~((hcnt_q >= pdc_pkg::HSYNC_START)
                          & (hcnt_q < pdc_pkg::HSYNC_END));
        link.vsync_n <= ~((vcnt_q >= pdc_pkg::VSYNC_START)
                          & (vcnt_q < pdc_pkg::VSYNC_END));
        if (ctrl_q[pdc_pkg::CTRL_PASS_SEL_BIT]) begin
          link.passthrough_blank_n <= ~in_blank;
          link.blank_n <= 1'b1;
        end else begin
          link.blank_n <= ~in_blank;
          link.passthrough_blank_n <= 1'b1;
        end
      end
    end
  end

endmodule : pdc_host

// file: bench/pdc_chk.sv
// Assertions on the link pins and the device outputs
`timescale 1ns/10ps
module pdc_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link pins
  input wire logic hsync_n,
  input wire logic wr_n,
  input wire logic [3:0] register_select,
  input wire logic [7:0] mpu_data,
  // Device outputs
  input wire logic [7:0] palette_addr_q,
  input wire logic [7:0] overlay_q,
  input wire logic [7:0] read_mask_q,
  input wire logic [7:0] mux_ctrl_q,
  input wire logic [7:0] video_output_control_q,
  input wire logic [7:0] load_count_q,
  input wire logic [7:0] control_count_q,
  input wire logic pedestal_on_q,
  input wire logic sync_on_green_q,
  input wire logic hsync_out_n_q,
  input wire logic vsync_out_n_q,
  input wire logic green_sync_off_q,
  input wire logic pass_mode_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////////
  sequence s_hw_strobe;
    $rose(wr_n) && register_select == pdc_pkg::RS_HW_RESET;
  endsequence
  sequence s_sw_strobe;
    $rose(wr_n) && register_select == pdc_pkg::RS_MUX_CTRL && mpu_data[5:0] == 6'h2d;
  endsequence
  // Mask must settle through the address flop before it is judged
  sequence s_mask_settled;
    $stable(read_mask_q) [*3];
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  AST_MASK_AND: assert property (s_mask_settled |-> (palette_addr_q & ~read_mask_q) == 8'h00)
    else $error("palette address has a bit outside the read mask");
  AST_ZERO_MASK: assert property (s_mask_settled ##0 read_mask_q == 8'h00 |-> palette_addr_q == 8'h00)
    else $error("zero mask did not select entry zero");
  AST_OVERLAY: assert property (s_mask_settled |-> (overlay_q & ~read_mask_q) == 8'h00)
    else $error("overlay bits escape the read mask");
  AST_HW_RESET: assert property (s_hw_strobe |-> ##4 read_mask_q == 8'hff && mux_ctrl_q == 8'h2d)
    else $error("hardware reset strobe did not restore registers");
  AST_SW_RESET: assert property (s_sw_strobe |-> ##4 read_mask_q == 8'hff && pass_mode_q)
    else $error("software reset did not restore registers");
  AST_COUNTERS: assert property (s_hw_strobe or s_sw_strobe
    |-> ##[3:5] load_count_q == 8'h00 && control_count_q == 8'h00)
    else $error("divider counters not cleared by reset");
  AST_PEDESTAL: assert property ($stable(video_output_control_q)
    |-> pedestal_on_q == video_output_control_q[pdc_pkg::PEDESTAL_BIT])
    else $error("pedestal output differs from control bit");
  AST_SYNC_GREEN: assert property ($stable(video_output_control_q)
    |-> sync_on_green_q == video_output_control_q[pdc_pkg::SYNC_ON_GREEN_BIT])
    else $error("sync on green output differs from control bit");
  AST_GREEN_OFF: assert property ($stable(hsync_out_n_q) && $stable(vsync_out_n_q)
    |-> green_sync_off_q == (!hsync_out_n_q || !vsync_out_n_q))
    else $error("green sync source not off during delayed sync");
  AST_SYNC_PIPE: assert property ($fell(hsync_n) && !pass_mode_q |-> ##[10:24] !hsync_out_n_q)
    else $error("delayed sync did not follow the sync input");
endmodule : pdc_chk

// file: bench/test_pdc.sv
// Bench joining controller and device ends over the pin link
`timescale 1ns/10ps
module test_pdc;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] pa, ovl, mux, icl, ocl, vc, rmask, lcnt, ccnt;
  logic hs_o, vs_o, bl_o, g_off, sog, ped, pmode;
  int fail_count, n_compared, cyc, i;
  pdc_link_if pdc_link_if_inst ();
  pdc_host pdc_host_inst (.link(pdc_link_if_inst.host), .pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  pdc_device pdc_device_inst (.link(pdc_link_if_inst.device), .pclk(pclk),
    .presetn(presetn), .palette_addr_q(pa), .overlay_q(ovl), .hsync_out_n_q(hs_o),
    .vsync_out_n_q(vs_o), .blank_out_n_q(bl_o), .green_sync_off_q(g_off),
    .sync_on_green_q(sog), .pedestal_on_q(ped), .pass_mode_q(pmode), .mux_ctrl_q(mux),
    .in_clk_sel_q(icl), .out_clk_sel_q(ocl), .video_output_control_q(vc),
    .read_mask_q(rmask), .load_count_q(lcnt), .control_count_q(ccnt));
  pdc_chk pdc_chk_inst (.pclk(pclk), .presetn(presetn), .hsync_n(pdc_link_if_inst.hsync_n),
    .wr_n(pdc_link_if_inst.wr_n), .register_select(pdc_link_if_inst.register_select),
    .mpu_data(pdc_link_if_inst.mpu_data), .palette_addr_q(pa), .overlay_q(ovl),
    .read_mask_q(rmask), .mux_ctrl_q(mux), .video_output_control_q(vc),
    .load_count_q(lcnt), .control_count_q(ccnt), .pedestal_on_q(ped),
    .sync_on_green_q(sog), .hsync_out_n_q(hs_o), .vsync_out_n_q(vs_o),
    .green_sync_off_q(g_off), .pass_mode_q(pmode));
  //////////////////////////////////////////////////////////////////////////////
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // Entered just after a rising edge; leaves one idle cycle behind it
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Looked at mid-cycle: the value seen is the one the next rising edge samples
    do @(negedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Commands sent while busy are dropped, so every command waits here
  task wait_idle;
    do apb(1'b0, pdc_pkg::APB_STATUS, 32'h0); while (rd[0] !== 1'b0);
  endtask : wait_idle
  task mpu(input logic [3:0] sel, input logic [7:0] d);
    apb(1'b1, pdc_pkg::APB_MPU_CMD, {20'h0, sel, d});
    wait_idle();
  endtask : mpu
  //////////////////////////////////////////////////////////////////////////////
  task t_reset;
    check("mux", mux, 8'h2d);
    check("in_clk", icl, 8'h00);
    check("out_clk", ocl, 8'h3f);
    check("vctrl", vc, 8'h03);
    check("mask", rmask, 8'hff);
    check("hsync_n idle", pdc_link_if_inst.hsync_n, 1'b1);
    apb(1'b0, 8'h40, 32'h0);
    check("slverr", err, 1'b1);
    check("rdata", rd, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task t_ctrl;
    mpu(pdc_pkg::RS_VIDEO_CTRL, 8'h13);
    check("vctrl", vc, 8'h13);
    check("pedestal", ped, 1'b1);
    check("sog", sog, 1'b0);
    mpu(pdc_pkg::RS_VIDEO_CTRL, 8'h23);
    check("pedestal", ped, 1'b0);
    check("sog", sog, 1'b1);
    $display("test control done");
  endtask : t_ctrl
  task t_mask;
    mpu(pdc_pkg::RS_MUX_CTRL, 8'h08);
    apb(1'b1, pdc_pkg::APB_PIXEL, 32'hffffffff);
    mpu(pdc_pkg::RS_READ_MASK, 8'h0f);
    apb(1'b1, pdc_pkg::APB_CTRL, 32'h1);
    repeat (40) @(posedge pclk);
    check("addr", pa, 8'h0f);
    check("overlay", ovl, 8'h0f);
    mpu(pdc_pkg::RS_OUT_CLK_SEL, 8'h01);
    apb(1'b1, pdc_pkg::APB_PIXEL, 32'h00030005);
    repeat (40) @(posedge pclk);
    check("group", pa, 8'h03);
    mpu(pdc_pkg::RS_PAGE, 8'h55);
    mpu(pdc_pkg::RS_READ_MASK, 8'h00);
    repeat (40) @(posedge pclk);
    check("addr", pa, 8'h00);
    check("overlay", ovl, 8'h00);
    $display("test mask done");
  endtask : t_mask
  task t_sync;
    for (i = 0; i < 8000 && pdc_link_if_inst.hsync_n !== 1'b0; i++) @(negedge pclk);
    check("blank with sync", pdc_link_if_inst.blank_n, 1'b0);
    for (i = 0; i < 40 && hs_o !== 1'b0; i++) @(negedge pclk);
    check("delayed sync", hs_o, 1'b0);
    repeat (2) @(posedge pclk);
    check("green off", g_off, 1'b1);
    apb(1'b1, pdc_pkg::APB_CTRL, 32'h0);
    repeat (60) @(posedge pclk);
    $display("test sync done");
  endtask : t_sync
  task t_resets;
    mpu(pdc_pkg::RS_READ_MASK, 8'h3c);
    mpu(pdc_pkg::RS_MUX_CTRL, 8'h6d);
    check("mask", rmask, 8'hff);
    check("mux", mux, 8'h2d);
    check("pass", pmode, 1'b1);
    mpu(pdc_pkg::RS_VIDEO_CTRL, 8'h33);
    mpu(pdc_pkg::RS_IN_CLK_SEL, 8'h05);
    apb(1'b1, pdc_pkg::APB_RESET_BURST, 32'h3);
    wait_idle();
    check("vctrl", vc, 8'h03);
    check("in_clk", icl, 8'h00);
    check("out_clk", ocl, 8'h3f);
    apb(1'b1, pdc_pkg::APB_CTRL, 32'h3);
    for (i = 0; i < 8000 && hs_o !== 1'b0; i++) @(negedge pclk);
    check("pass sync", hs_o, 1'b0);
    check("pass blank", bl_o, 1'b0);
    $display("test resets done");
  endtask : t_resets
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_ctrl();
    t_mask();
    t_sync();
    t_resets();
    end_sim();
  end
endmodule : test_pdc
